// *** hdl/pcs_status_pkg.sv ***
// shared constants and carriers for the pcs channel status block
// assumes one core clock; every user of it names package::item in full
package pcs_status_pkg;

	// ==========================================================
	// status word layout
	localparam int STATUS_W = 16;
	localparam int BIT_LINK = 0;
	localparam int BIT_SYNC = 1;
	localparam int BIT_RUDI_CFG = 2;
	localparam int BIT_RUDI_IDLE = 3;
	localparam int BIT_RUDI_INV = 4;
	localparam int BIT_DISP_ERR = 5;
	localparam int RSVD_W = 10;

	// ==========================================================
	// advertisement register and control register fields
	localparam int ADV_W = 16;
	localparam logic [15:0] ADV_RESET = 16'h0000;
	localparam int CTRL_RESTART_BIT = 9;

	// status word as seen by the client; upper bits lie outside this block
	typedef struct packed {
		logic [9:0] rsvd;
		logic disp_err;
		logic rudi_invalid;
		logic rudi_idle;
		logic rudi_config;
		logic sync;
		logic link;
	} status_s;

	localparam status_s STATUS_RESET = '{default: 1'b0};

	// receive-side indications from the sync machine and decoder
	typedef struct packed {
		logic sync_ok;
		logic rudi_config;
		logic rudi_idle;
		logic rudi_invalid;
		logic disp_err;
	} rx_ind_s;

endpackage

// *** hdl/pcs_link_status_config.sv ***
// status word and configuration strobes of one pcs channel
// assumes sync, negotiation and decoder logic run on clk; sync and decoder feed rx_ind;
// client strobes are also launched from clk, so no synchroniser is used
`timescale 1ns/1ps

module pcs_link_status_config #(
	parameter bit AN_PRESENT = 1'b1,
	parameter bit MDIO_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// receive indications and negotiation state
	input wire pcs_status_pkg::rx_ind_s rx_ind,
	input wire logic an_enable,
	input wire logic an_complete,
	input wire logic restart_done,
	// management write of the advertisement register
	input wire logic mgmt_adv_we,
	input wire logic [pcs_status_pkg::ADV_W-1:0] mgmt_adv_data,
	// client configuration strobes
	input wire logic advert_load_strobe,
	input wire logic [pcs_status_pkg::ADV_W-1:0] advert_input_vector,
	input wire logic negotiation_restart_strobe,
	// outputs to client and negotiation machine
	output pcs_status_pkg::status_s status_vector,
	output logic [pcs_status_pkg::ADV_W-1:0] advert_reg,
	output logic ctrl_restart
);

	// ==========================================================
	// reset release
	logic rst_sync1_q;
	logic rst_n_q;
	logic run_q;

	// two stages so the release never lands near a clock edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_n_q <= rst_sync1_q;
		end
	end

	// marks cycles whose previous cycle was already out of reset
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			run_q <= 1'b0;
		end else begin
			run_q <= 1'b1;
		end
	end

	// ==========================================================
	// link qualification
	logic an_active;
	logic link_d;
	pcs_status_pkg::status_s status_q;
	pcs_status_pkg::status_s status_d;

	// negotiation only qualifies the link if it exists and is switched on
	assign an_active = AN_PRESENT && an_enable;

	// without negotiation the link bit collapses onto sync
	assign link_d = rx_ind.sync_ok && (!an_active || an_complete);

	// status word assembly; upper bits belong to other logic and stay low
	always_comb begin
		status_d = pcs_status_pkg::STATUS_RESET;
		status_d.link = link_d;
		status_d.sync = rx_ind.sync_ok;
		status_d.rudi_config = rx_ind.rudi_config;
		status_d.rudi_idle = rx_ind.rudi_idle;
		status_d.rudi_invalid = rx_ind.rudi_invalid;
		status_d.disp_err = rx_ind.disp_err;
	end

	// one register for the whole word keeps link and sync cycle-aligned,
	// so the link bit always matches whichever source it is tied to
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= pcs_status_pkg::STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// the management link status bit is read from this same flop
	assign status_vector = status_q;

	// ==========================================================
	// strobe edge detection
	logic adv_strobe_q;
	logic restart_strobe_q;
	logic adv_edge;
	logic restart_edge;

	// registered copies; reset clears them, so a strobe held high through reset gives one edge
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			adv_strobe_q <= 1'b0;
			restart_strobe_q <= 1'b0;
		end else begin
			adv_strobe_q <= advert_load_strobe;
			restart_strobe_q <= negotiation_restart_strobe;
		end
	end

	// rising edge of a strobe against its copy from the previous edge
	function automatic logic rise_of(input logic now_lvl,
		input logic old_lvl);
		rise_of = now_lvl && !old_lvl;
	endfunction

	// a level held high gives one edge only; the client must drop it.
	// the strobes must come from clk logic: an asynchronous source would
	// need synchronising before it reaches these comparisons
	assign adv_edge = rise_of(advert_load_strobe, adv_strobe_q);
	assign restart_edge = rise_of(negotiation_restart_strobe,
		restart_strobe_q);

	// ==========================================================
	// advertisement register
	logic [pcs_status_pkg::ADV_W-1:0] adv_q;

	// the strobe outranks a management write in the same cycle
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			adv_q <= pcs_status_pkg::ADV_RESET;
		end else if (MDIO_PRESENT && adv_edge) begin
			adv_q <= advert_input_vector;
		end else if (MDIO_PRESENT && mgmt_adv_we) begin
			adv_q <= mgmt_adv_data;
		end
	end

	assign advert_reg = adv_q;

	// ==========================================================
	// restart bit of the control register
	logic restart_q;

	// set wins over the self-clear so a late edge is never dropped
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			restart_q <= 1'b0;
		end else if (AN_PRESENT && restart_edge) begin
			restart_q <= 1'b1;
		end else if (restart_done) begin
			restart_q <= 1'b0;
		end
	end

	assign ctrl_restart = restart_q;

	// ==========================================================
	// checks

	chk_link_needs_sync: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		status_q.link |-> status_q.sync && $past(rx_ind.sync_ok)
	) else $error("link bit high without sync");

	chk_link_drop_cause: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && $past(!rx_ind.sync_ok || (an_active && !an_complete))
		|-> !status_q.link
	) else $error("link bit high after sync loss or open negotiation");

	chk_link_an_mode: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && $past(an_active)
		|-> status_q.link == $past(rx_ind.sync_ok && an_complete)
	) else $error("link bit differs from negotiated link status");

	chk_link_plain_mode: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && $past(!an_active) |-> status_q.link == status_q.sync
	) else $error("link bit differs from sync bit without negotiation");

	chk_sync_follows: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q |-> status_q.sync == $past(rx_ind.sync_ok)
	) else $error("sync bit does not follow sync status");

	chk_rudi_config: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q |-> status_q.rudi_config == $past(rx_ind.rudi_config)
	) else $error("config reception bit missed");

	chk_rudi_idle: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q |-> status_q.rudi_idle == $past(rx_ind.rudi_idle)
	) else $error("idle reception bit missed");

	chk_rudi_invalid: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q |-> status_q.rudi_invalid == $past(rx_ind.rudi_invalid)
	) else $error("invalid reception bit wrong");

	chk_disparity_flag: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && rx_ind.disp_err ##1 !rx_ind.disp_err
		|-> status_q.disp_err ##1 !status_q.disp_err
	) else $error("disparity flag not raised for one error");

	chk_adv_load: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		MDIO_PRESENT && !advert_load_strobe ##1 advert_load_strobe
		|=> advert_reg == $past(advert_input_vector)
	) else $error("advert register not loaded on strobe edge");

	chk_adv_held_level: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && advert_load_strobe && $past(advert_load_strobe)
		&& !mgmt_adv_we |=> $stable(advert_reg)
	) else $error("advert register reloaded without a fresh edge");

	chk_adv_gated: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		!MDIO_PRESENT |-> advert_reg == pcs_status_pkg::ADV_RESET
	) else $error("advert register changed without management");

	chk_restart_set: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && AN_PRESENT && negotiation_restart_strobe
		&& !restart_strobe_q |=> ctrl_restart
	) else $error("restart bit not set on strobe edge");

	chk_restart_gated: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		!AN_PRESENT |-> !ctrl_restart
	) else $error("restart bit set without negotiation");

	chk_restart_set_wins: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && AN_PRESENT && restart_edge && restart_done
		|=> ctrl_restart
	) else $error("restart edge lost to simultaneous clear");

	chk_restart_clear: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		restart_done && !restart_edge |=> !ctrl_restart
	) else $error("restart bit not cleared when done");

	// guards on strobe copies, on what may change the two registers and on the disparity flag
	chk_copies_cleared: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		!run_q |-> !adv_strobe_q && !restart_strobe_q
	) else $error("strobe copies not cleared by reset");

	chk_restart_held: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && negotiation_restart_strobe && restart_strobe_q
		&& !ctrl_restart |=> !ctrl_restart
	) else $error("restart bit set by a held strobe");

	chk_restart_needs_edge: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		!ctrl_restart && !(AN_PRESENT && restart_edge)
		|=> !ctrl_restart
	) else $error("restart bit set without an honoured edge");

	chk_restart_stays: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && ctrl_restart && !restart_done |=> ctrl_restart
	) else $error("restart bit dropped before done");

	chk_adv_mgmt_write: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q && MDIO_PRESENT && mgmt_adv_we && !adv_edge
		|=> advert_reg == $past(mgmt_adv_data)
	) else $error("management write to advert register lost");

	chk_adv_only_on_cause: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		!adv_edge && !mgmt_adv_we |=> $stable(advert_reg)
	) else $error("advert register changed without edge or write");

	chk_disp_follows: assert property (
		@(posedge clk) disable iff (!rst_n_q)
		run_q |-> status_q.disp_err == $past(rx_ind.disp_err)
	) else $error("disparity flag does not follow errors");

endmodule

// *** testbench/client_strobe_model.sv ***
// client-side model that drives the configuration strobes of one channel
// assumes the bench calls its tasks and clk is the core clock
`timescale 1ns/1ps

module client_strobe_model (
	// clock
	input wire logic clk,
	// configuration strobes toward the channel
	output logic advert_load_strobe,
	output logic [pcs_status_pkg::ADV_W-1:0] advert_input_vector,
	output logic negotiation_restart_strobe
);
	// ==========================================================
	// idle levels from time zero
	initial begin
		advert_load_strobe = 1'b0;
		advert_input_vector = 16'h0000;
		negotiation_restart_strobe = 1'b0;
	end

	// ==========================================================
	// drop then raise, so each request is a fresh rising edge
	task automatic load(input logic [15:0] v);
		@(negedge clk);
		advert_load_strobe = 1'b0;
		@(negedge clk);
		advert_input_vector = v;
		advert_load_strobe = 1'b1;
	endtask

	// change the vector while the strobe stays high: no new load expected
	task automatic hold(input logic [15:0] v);
		@(negedge clk);
		advert_input_vector = v;
	endtask

	task automatic restart();
		@(negedge clk);
		negotiation_restart_strobe = 1'b0;
		@(negedge clk);
		negotiation_restart_strobe = 1'b1;
	endtask
endmodule

// *** testbench/pcs_link_status_config_test.sv ***
// self-checking bench for the channel status and configuration strobes
// assumes 125 MHz core clock; a second instance lacks negotiation and mgmt
`timescale 1ns/1ps

module pcs_link_status_config_test;
	// ==========================================================
	// stimulus and observed signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	pcs_status_pkg::rx_ind_s rx_ind = '0;
	logic an_enable = 1'b0;
	logic an_complete = 1'b0;
	logic restart_done = 1'b0;
	logic mgmt_adv_we = 1'b0;
	logic [15:0] mgmt_adv_data = 16'h0000;
	logic ld;
	logic rs;
	logic [15:0] vec;
	pcs_status_pkg::status_s sv;
	pcs_status_pkg::status_s sv_bare;
	logic [15:0] adv;
	logic [15:0] adv_bare;
	logic rq;
	logic rq_bare;
	int err_total = 0;
	int samples_checked = 0;

	always #4 clk = ~clk;

	client_strobe_model i_client (.clk(clk), .advert_load_strobe(ld),
		.advert_input_vector(vec), .negotiation_restart_strobe(rs));

	pcs_link_status_config i_dut (.clk(clk), .rst_b(rst_b),
		.rx_ind(rx_ind), .an_enable(an_enable), .an_complete(an_complete),
		.restart_done(restart_done), .mgmt_adv_we(mgmt_adv_we),
		.mgmt_adv_data(mgmt_adv_data), .advert_load_strobe(ld),
		.advert_input_vector(vec), .negotiation_restart_strobe(rs),
		.status_vector(sv), .advert_reg(adv), .ctrl_restart(rq));

	// same stimulus, but built without negotiation and management
	pcs_link_status_config #(.AN_PRESENT(1'b0), .MDIO_PRESENT(1'b0))
	i_dut_bare (.clk(clk), .rst_b(rst_b),
		.rx_ind(rx_ind), .an_enable(an_enable), .an_complete(an_complete),
		.restart_done(restart_done), .mgmt_adv_we(mgmt_adv_we),
		.mgmt_adv_data(mgmt_adv_data), .advert_load_strobe(ld),
		.advert_input_vector(vec), .negotiation_restart_strobe(rs),
		.status_vector(sv_bare), .advert_reg(adv_bare),
		.ctrl_restart(rq_bare));

	// ==========================================================
	// comparisons and closing
	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		check16({15'h0, got}, {15'h0, exp});
	endtask

	task automatic complete_run();
		$display("err_total=%0d samples_checked=%0d", err_total,
			samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// a hang would otherwise stall the run; tests need under 400 cycles
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [6:0] c;
		logic lk;
		logic [15:0] es;
		logic [15:0] eb;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		check16(sv, 16'h0000);
		check16(adv, 16'h0000);
		check1(rq, 1'b0);
		// every indication, enable and completion combination
		for (int i = 0; i < 128; i++) begin
			c = i[6:0];
			rx_ind = c[4:0];
			an_enable = c[5];
			an_complete = c[6];
			@(negedge clk);
			lk = c[4] & (~c[5] | c[6]);
			es = {10'h0, c[0], c[1], c[2], c[3], c[4], lk};
			eb = {10'h0, c[0], c[1], c[2], c[3], c[4], c[4]};
			check16(sv, es);
			check1(sv.sync, c[4]);
			check1(sv.rudi_config, c[3]);
			check1(sv.rudi_idle, c[2]);
			check1(sv.rudi_invalid, c[1]);
			check1(sv.disp_err, c[0]);
			check16(sv_bare, eb);
		end
		i_client.load(16'h1234);
		@(negedge clk);
		check16(adv, 16'h1234);
		i_client.hold(16'hbeef);
		@(negedge clk);
		check16(adv, 16'h1234);
		mgmt_adv_we = 1'b1;
		mgmt_adv_data = 16'h5a5a;
		@(negedge clk);
		mgmt_adv_we = 1'b0;
		@(negedge clk);
		check16(adv, 16'h5a5a);
		// a fresh edge in the same cycle as a management write wins
		fork
			i_client.load(16'hc3c3);
			begin
				repeat (2) @(negedge clk);
				mgmt_adv_we = 1'b1;
				mgmt_adv_data = 16'h0f0f;
			end
		join
		@(negedge clk);
		mgmt_adv_we = 1'b0;
		check16(adv, 16'hc3c3);
		check16(adv_bare, 16'h0000);
		i_client.restart();
		@(negedge clk);
		check1(rq, 1'b1);
		restart_done = 1'b1;
		@(negedge clk);
		restart_done = 1'b0;
		check1(rq, 1'b0);
		@(negedge clk);
		check1(rq, 1'b0);
		i_client.restart();
		@(negedge clk);
		check1(rq, 1'b1);
		check1(rq_bare, 1'b0);
		// restart edge in the same cycle as restart_done: the set wins
		restart_done = 1'b1;
		i_client.restart();
		@(negedge clk);
		check1(rq, 1'b1);
		@(negedge clk);
		restart_done = 1'b0;
		check1(rq, 1'b0);
		// reset in mid-run with both strobes still high
		rst_b = 1'b0;
		i_client.hold(16'h7e81);
		check16(sv, 16'h0000);
		check16(adv, 16'h0000);
		check1(rq, 1'b0);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		// cleared copies turn the held strobes into one edge each
		check16(adv, 16'h7e81);
		check1(rq, 1'b1);
		check16(sv, 16'h003f);
		check16(sv_bare, 16'h003f);
		check16(adv_bare, 16'h0000);
		check1(rq_bare, 1'b0);
		complete_run();
	end
endmodule
